// ==== inc/prx_consts.vh ====
/*
 * constants for the receive and status signalling block: interface modes,
 * fifo shape, heartbeat timing. assumes the system clock period below.
 */
`ifndef PRX_CONSTS_VH
`define PRX_CONSTS_VH

`define PRX_MODE_MII 2'h0
`define PRX_MODE_RMII 2'h1
`define PRX_MODE_SERIAL 2'h2

`define PRX_FIFO_WIDTH 4
`define PRX_FIFO_DEPTH 32
`define PRX_FIFO_AW 5

`define PRX_CLK_PERIOD_PS 8000
`define PRX_SQE_TIME_NS 1000
`define PRX_SQE_CYCLES ((`PRX_SQE_TIME_NS * 1000 + `PRX_CLK_PERIOD_PS - 1) / `PRX_CLK_PERIOD_PS)
`define PRX_SQE_CNT_W 8

`define PRX_STRAP_SETTLE 2'h2

`endif

// ==== hdl/prx_fifo.v ====
/*
 * flip-flop fifo with valid/ready on both sides.
 * assumes one clock for writer and reader; async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module prx_fifo #(
	parameter WIDTH = 4,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk_in,
	input wire rstn_in,
	input wire in_valid_in,
	input wire [WIDTH-1:0] in_data_in,
	output wire in_ready_out,
	output wire out_valid_out,
	output wire [WIDTH-1:0] out_data_out,
	input wire out_ready_in
);
	localparam integer DEPTH_INT = DEPTH;
	localparam integer LAST_INT = DEPTH - 1;
	localparam [AW:0] FULL_CNT = DEPTH_INT[AW:0];
	localparam [AW-1:0] LAST_PTR = LAST_INT[AW-1:0];

	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	function [AW-1:0] next_ptr;
		input [AW-1:0] p;
		begin
			next_ptr = (p == LAST_PTR) ? {AW{1'b0}} : p + 1'b1;
		end
	endfunction

	assign in_ready_out = (count_r != FULL_CNT);
	assign out_valid_out = (count_r != {(AW+1){1'b0}});
	assign out_data_out = mem_r[rd_ptr_r];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;

	always @(posedge clk_in) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= next_ptr(wr_ptr_r);
			end
			if (pop) begin
				rd_ptr_r <= next_ptr(rd_ptr_r);
			end
			if (push & !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop & !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // prx_fifo

`default_nettype wire

// ==== hdl/prx_rx_status.v ====
/*
 * receive data, carrier, collision and forwarded reference clock toward the
 * mac, for mii, rmii and 10 Mb/s serial mode. assumes the phy core hands
 * nibbles on the system clock; the reference and recovered receive clocks,
 * transmit enable and strap are pins and are synchronised here.
 */
// Overview of operation
// R1: rmii dibits follow the reference clock
// R2: serial mode sends one bit, rxd[3:1] unused
// R3: mii carrier sense follows medium activity
// R4: serial carrier sense frames the receive bit
// R5: rmii merges carrier and data valid
// R6: half duplex collision on simultaneous activity
// R7: 10 Mb/s heartbeat pulse after transmit ends
// R8: full duplex collision always low
// R9: rmii controller derives collision itself
// R10: serial mode collision on simultaneous activity
// R11: forward reference clock, 25 or 50 MHz
// R12: strap switches the forwarded clock off
// R13: controller samples all on data clock edge
`timescale 1ns/1ps
`default_nettype none
`include "prx_consts.vh"

module prx_rx_status #(
	parameter FIFO_DEPTH = `PRX_FIFO_DEPTH,
	parameter FIFO_AW = `PRX_FIFO_AW
) (
	input wire MCLK_IN,
	input wire RSTN_IN,
	input wire [1:0] MODE_SEL_IN,
	input wire SPEED_10_IN,
	input wire FULL_DUPLEX_IN,
	input wire HEARTBEAT_EN_IN,
	input wire REF_CLK_IN,
	input wire RX_CLK_IN,
	input wire TX_EN_IN,
	input wire FWD_CLK_DIS_STRAP_IN,
	input wire RX_ACTIVE_IN,
	input wire RX_VALID_IN,
	input wire [3:0] RX_DATA_IN,
	output wire RX_READY_OUT,
	output wire [3:0] RXD_OUT,
	output wire RX_DV_OUT,
	output wire CRS_OUT,
	output wire COL_OUT,
	output wire FWD_REF_CLK_OUT
);
	reg ref_s1_r, ref_s2_r, ref_d_r;
	reg rxc_s1_r, rxc_s2_r, rxc_d_r;
	reg tx_s1_r, tx_s2_r, tx_d_r;
	reg strap_s1_r, strap_s2_r;
	reg [1:0] settle_r;
	reg fwd_dis_r;
	reg fwd_clk_r;
	reg [3:0] word_r;
	reg [1:0] left_r;
	reg [3:0] rxd_r;
	reg dv_r;
	reg crs_r;
	reg col_r;
	reg [`PRX_SQE_CNT_W-1:0] sqe_cnt_r;
	reg crs_nxt;
	reg col_nxt;
	reg [`PRX_SQE_CNT_W-1:0] sqe_cnt_nxt;

	wire is_rmii;
	wire is_serial;
	wire ref_rise;
	wire rxc_rise;
	wire act_edge;
	wire pop;
	wire f_valid;
	wire [3:0] f_data;
	wire [3:0] shifted;
	wire tx_fall;

	localparam integer SQE_CYCLES_INT = `PRX_SQE_CYCLES;
	localparam [`PRX_SQE_CNT_W-1:0] SQE_LOAD = SQE_CYCLES_INT[`PRX_SQE_CNT_W-1:0];

	// pin bits placed on rxd for the current part of a nibble
	function [3:0] lane_bits;
		input [1:0] mode;
		input [3:0] d;
		begin
			case (mode)
				`PRX_MODE_RMII: lane_bits = {2'b00, d[1:0]};
				`PRX_MODE_SERIAL: lane_bits = {3'b000, d[0]};
				default: lane_bits = d;
			endcase
		end
	endfunction

	// parts still to send after the first one of a nibble
	function [1:0] extra_parts;
		input [1:0] mode;
		begin
			case (mode)
				`PRX_MODE_RMII: extra_parts = 2'h1;
				`PRX_MODE_SERIAL: extra_parts = 2'h3;
				default: extra_parts = 2'h0;
			endcase
		end
	endfunction

	assign is_rmii = (MODE_SEL_IN == `PRX_MODE_RMII);
	assign is_serial = (MODE_SEL_IN == `PRX_MODE_SERIAL);

	// edges found from the second stage only; first stage feeds nothing else
	assign ref_rise = ref_s2_r & !ref_d_r;
	assign rxc_rise = rxc_s2_r & !rxc_d_r;
	assign act_edge = is_rmii ? ref_rise : rxc_rise; // [R1] [R2]
	assign tx_fall = tx_d_r & !tx_s2_r;

	// a new nibble leaves the fifo only when the previous one is fully sent
	assign pop = act_edge & (left_r == 2'h0) & f_valid;
	assign shifted = is_rmii ? {2'b00, word_r[3:2]} : {1'b0, word_r[3:1]};

	prx_fifo #(
		.WIDTH(`PRX_FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_in(MCLK_IN),
		.rstn_in(RSTN_IN),
		.in_valid_in(RX_VALID_IN),
		.in_data_in(RX_DATA_IN),
		.in_ready_out(RX_READY_OUT),
		.out_valid_out(f_valid),
		.out_data_out(f_data),
		.out_ready_in(pop)
	);

	always @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ref_s1_r <= 1'b0;
			ref_s2_r <= 1'b0;
			ref_d_r <= 1'b0;
			rxc_s1_r <= 1'b0;
			rxc_s2_r <= 1'b0;
			rxc_d_r <= 1'b0;
			tx_s1_r <= 1'b0;
			tx_s2_r <= 1'b0;
			tx_d_r <= 1'b0;
			strap_s1_r <= 1'b0;
			strap_s2_r <= 1'b0;
		end else begin
			ref_s1_r <= REF_CLK_IN;
			ref_s2_r <= ref_s1_r;
			ref_d_r <= ref_s2_r;
			rxc_s1_r <= RX_CLK_IN;
			rxc_s2_r <= rxc_s1_r;
			rxc_d_r <= rxc_s2_r;
			tx_s1_r <= TX_EN_IN;
			tx_s2_r <= tx_s1_r;
			tx_d_r <= tx_s2_r;
			strap_s1_r <= FWD_CLK_DIS_STRAP_IN;
			strap_s2_r <= strap_s1_r;
		end
	end

	// strap caught once the synchroniser has settled after reset release
	always @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			settle_r <= 2'h0;
			fwd_dis_r <= 1'b1;
			fwd_clk_r <= 1'b0;
		end else begin
			// count one past the capture point so the strap is taken exactly once
			if (settle_r != (`PRX_STRAP_SETTLE + 2'h1)) begin
				settle_r <= settle_r + 2'h1;
			end
			// second stage holds the pin only from the second edge after release
			if (settle_r == `PRX_STRAP_SETTLE) begin
				fwd_dis_r <= strap_s2_r; // [R12]
			end
			// forwarded copy is only as clean as 125 MHz sampling allows
			fwd_clk_r <= !fwd_dis_r & ref_s2_r; // [R11] [R12]
		end
	end

	// nibble splitter: mii whole, rmii two dibits, serial four bits, lsb first
	always @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			word_r <= 4'h0;
			left_r <= 2'h0;
			rxd_r <= 4'h0;
			dv_r <= 1'b0;
		end else if (act_edge) begin
			if (left_r != 2'h0) begin
				word_r <= shifted;
				left_r <= left_r - 2'h1;
				rxd_r <= lane_bits(MODE_SEL_IN, shifted); // [R1] [R2]
				dv_r <= 1'b1;
			end else if (f_valid) begin
				word_r <= f_data;
				left_r <= extra_parts(MODE_SEL_IN);
				rxd_r <= lane_bits(MODE_SEL_IN, f_data); // [R1] [R2]
				dv_r <= 1'b1;
			end else begin
				rxd_r <= 4'h0;
				dv_r <= 1'b0;
			end
		end
	end

	always @* begin
		case (MODE_SEL_IN)
			`PRX_MODE_RMII: crs_nxt = RX_ACTIVE_IN | dv_r | f_valid; // [R5] [R9]
			// held until the last bit is out so every bit lies inside carrier
			`PRX_MODE_SERIAL: crs_nxt = RX_ACTIVE_IN | dv_r | f_valid; // [R4] [R2]
			default: crs_nxt = RX_ACTIVE_IN; // [R3]
		endcase
	end

	always @* begin
		sqe_cnt_nxt = sqe_cnt_r;
		if (sqe_cnt_r != {`PRX_SQE_CNT_W{1'b0}}) begin
			sqe_cnt_nxt = sqe_cnt_r - 1'b1;
		end
		if (tx_fall & SPEED_10_IN & !FULL_DUPLEX_IN & HEARTBEAT_EN_IN & !is_rmii) begin
			sqe_cnt_nxt = SQE_LOAD; // [R7]
		end
		if (FULL_DUPLEX_IN | is_rmii) begin
			col_nxt = 1'b0; // [R8] [R9]
		end else begin
			// serial mode is 10 Mb/s half duplex by nature
			col_nxt = (tx_s2_r & RX_ACTIVE_IN) // [R6] [R10]
				| (sqe_cnt_r != {`PRX_SQE_CNT_W{1'b0}}); // [R7]
		end
	end

	always @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			crs_r <= 1'b0;
			col_r <= 1'b0;
			sqe_cnt_r <= {`PRX_SQE_CNT_W{1'b0}};
		end else begin
			crs_r <= crs_nxt;
			col_r <= col_nxt;
			sqe_cnt_r <= sqe_cnt_nxt;
		end
	end

	assign RXD_OUT = rxd_r;
	assign RX_DV_OUT = dv_r;
	assign CRS_OUT = crs_r;
	assign COL_OUT = col_r;
	assign FWD_REF_CLK_OUT = fwd_clk_r;
endmodule // prx_rx_status

`default_nettype wire

// ==== tb/prx_rx_status_props.sv ====
/* port assertions for the receive/status block.
 * assumes a bind to prx_rx_status, one system clock. */
`timescale 1ns/1ps
`default_nettype none

module prx_rx_status_props (
	input wire logic MCLK_IN,
	input wire logic RSTN_IN,
	input wire logic [1:0] MODE_SEL_IN,
	input wire logic SPEED_10_IN,
	input wire logic FULL_DUPLEX_IN,
	input wire logic HEARTBEAT_EN_IN,
	input wire logic REF_CLK_IN,
	input wire logic TX_EN_IN,
	input wire logic FWD_CLK_DIS_STRAP_IN,
	input wire logic RX_ACTIVE_IN,
	input wire logic RX_DV_OUT,
	input wire logic CRS_OUT,
	input wire logic COL_OUT,
	input wire logic FWD_REF_CLK_OUT
);
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RSTN_IN);
	logic [3:0] up_r;
	// strap capture and sync settle well inside 8 cycles
	wire logic up = up_r == 4'h8;
	wire logic half = !FULL_DUPLEX_IN && MODE_SEL_IN != 2'h1;
	always @(posedge MCLK_IN or negedge RSTN_IN)
		if (!RSTN_IN) up_r <= 4'h0;
		else if (!up) up_r <= up_r + 4'h1;
	full_dup_a: assert property (FULL_DUPLEX_IN && $past(FULL_DUPLEX_IN) |-> !COL_OUT)
		else $error("collision in full duplex");
	mii_crs_a: assert property (MODE_SEL_IN == 2'h0 && $past(MODE_SEL_IN) == 2'h0
		|-> CRS_OUT == $past(RX_ACTIVE_IN)) else $error("mii carrier wrong");
	half_col_a: assert property (half && $past(TX_EN_IN, 3) && $past(TX_EN_IN, 2)
		&& $past(RX_ACTIVE_IN) |-> COL_OUT) else $error("collision missing");
	col_cause_a: assert property (COL_OUT && $past(RX_ACTIVE_IN) |-> $past(TX_EN_IN, 3))
		else $error("collision without transmit");
	heartbeat_a: assert property (half && SPEED_10_IN && HEARTBEAT_EN_IN && !RX_ACTIVE_IN
		&& $fell(TX_EN_IN) |-> ##[3:6] $rose(COL_OUT) ##124 COL_OUT ##1 !COL_OUT)
		else $error("heartbeat length wrong");
	fwd_clk_a: assert property (up && !FWD_CLK_DIS_STRAP_IN
		|-> FWD_REF_CLK_OUT == $past(REF_CLK_IN, 3)) else $error("forwarded clock wrong");
	fwd_off_a: assert property (up && FWD_CLK_DIS_STRAP_IN |-> !FWD_REF_CLK_OUT)
		else $error("forwarded clock not off");
	crs_frames_a: assert property (RX_DV_OUT && MODE_SEL_IN != 2'h0 |-> CRS_OUT)
		else $error("data outside carrier");
	hb_c: cover property ($fell(COL_OUT) && MODE_SEL_IN == 2'h2);
	rmii_c: cover property (RX_DV_OUT && MODE_SEL_IN == 2'h1);
	col_c: cover property (COL_OUT && RX_ACTIVE_IN);
endmodule // prx_rx_status_props

bind prx_rx_status prx_rx_status_props i_prx_rx_status_props (.MCLK_IN(MCLK_IN),
	.RSTN_IN(RSTN_IN), .MODE_SEL_IN(MODE_SEL_IN), .SPEED_10_IN(SPEED_10_IN),
	.FULL_DUPLEX_IN(FULL_DUPLEX_IN), .HEARTBEAT_EN_IN(HEARTBEAT_EN_IN),
	.REF_CLK_IN(REF_CLK_IN), .TX_EN_IN(TX_EN_IN), .FWD_CLK_DIS_STRAP_IN(FWD_CLK_DIS_STRAP_IN),
	.RX_ACTIVE_IN(RX_ACTIVE_IN), .RX_DV_OUT(RX_DV_OUT), .CRS_OUT(CRS_OUT), .COL_OUT(COL_OUT),
	.FWD_REF_CLK_OUT(FWD_REF_CLK_OUT));

`default_nettype wire

// ==== tb/prx_mac_model.sv ====
/* controller side: rebuilds nibbles from the receive pins.
 * assumes data valid holds through each whole nibble. */
`timescale 1ns/1ps
`default_nettype none

module prx_mac_model (
	input wire logic clk_in,
	input wire logic [1:0] mode_in,
	input wire logic [3:0] rxd_in,
	input wire logic dv_in,
	input wire logic crs_in,
	input wire logic tx_en_in,
	output logic [3:0] nib_out,
	output logic stb_out,
	output logic col_out
);
	logic [3:0] sh_r;
	logic [1:0] cnt_r = 2'h0;
	wire logic [1:0] last = mode_in == 2'h1 ? 2'h1 : {2{mode_in[1]}};
	wire logic [3:0] nx = mode_in == 2'h1 ? {rxd_in[1:0], sh_r[3:2]} :
		mode_in == 2'h2 ? {rxd_in[0], sh_r[3:1]} : rxd_in;
	// no collision pin in rmii, so it is rebuilt here
	assign col_out = mode_in == 2'h1 && crs_in && tx_en_in;
	initial stb_out = 1'b0;
	always @(posedge clk_in) begin
		stb_out <= 1'b0;
		if (dv_in !== 1'b1) cnt_r <= 2'h0;
		else begin
			cnt_r <= cnt_r == last ? 2'h0 : cnt_r + 2'h1;
			sh_r <= nx;
			if (cnt_r == last) begin
				nib_out <= nx;
				stb_out <= 1'b1;
			end
		end
	end
endmodule // prx_mac_model

`default_nettype wire

// ==== tb/prx_rx_status_test.sv ====
/* bench: fifo filled and drained in every mode, collision, heartbeat,
 * forwarded clock and strap. assumes the mac model and checker. */
`timescale 1ns/1ps
`default_nettype none

module prx_rx_status_test;
	localparam logic [9:0] CM = 10'h048;
	localparam logic [4:0] FD = 5'h04;
	logic hb = 1'b1;
	logic mclk = 1'b0, rstn = 1'b0, lclk = 1'b0, lrun = 1'b0, ec;
	logic spd = 1'b0, fd = 1'b0, txen = 1'b0, strap = 1'b0, act = 1'b0, vld = 1'b0, seen = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [3:0] dat = 4'h0;
	logic [7:0] k;
	logic [31:0] seed = 32'h4C04;
	logic [3:0] q[$];
	int n_mismatch = 0, comparisons = 0;
	wire logic rdy, dv, crs, col, fwd, stb, mcol;
	wire logic [3:0] rxd, nib;
	prx_rx_status i_prx_rx_status (.MCLK_IN(mclk), .RSTN_IN(rstn), .MODE_SEL_IN(mode),
		.SPEED_10_IN(spd), .FULL_DUPLEX_IN(fd), .HEARTBEAT_EN_IN(hb), .REF_CLK_IN(lclk),
		.RX_CLK_IN(lclk), .TX_EN_IN(txen), .FWD_CLK_DIS_STRAP_IN(strap), .RX_ACTIVE_IN(act),
		.RX_VALID_IN(vld), .RX_DATA_IN(dat), .RX_READY_OUT(rdy), .RXD_OUT(rxd), .RX_DV_OUT(dv),
		.CRS_OUT(crs), .COL_OUT(col), .FWD_REF_CLK_OUT(fwd));
	prx_mac_model i_prx_mac_model (.clk_in(lclk), .mode_in(mode), .rxd_in(rxd), .dv_in(dv),
		.crs_in(crs), .tx_en_in(txen), .nib_out(nib), .stb_out(stb), .col_out(mcol));
	always #4 mclk = ~mclk;
	// link clock off the system grid, still between frames
	initial begin
		#3;
		forever #32 if (lrun) lclk = ~lclk;
	end
	always @(posedge mclk) if (fwd === 1'b1) seen <= 1'b1;
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic do_reset(input logic s);
		rstn <= 1'b0;
		strap <= s;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
	endtask
	always @(negedge lclk)
		if (stb === 1'b1)
			chk("nibble", q.size() ? {4'h0, q.pop_front()} : 8'hFF, {4'h0, nib});
	initial begin
		int m, i;
		do_reset(1'b0);
		for (m = 0; m < 3; m++) begin
			mode <= m[1:0];
			for (i = 0; i < 33; i++) begin
				seed = lfsr_next(seed);
				vld <= 1'b1;
				dat <= seed[3:0];
				if (i < 32) q.push_back(seed[3:0]);
				@(posedge mclk);
			end
			vld <= 1'b0;
			#1 chk("ready when full", 8'h0, {7'h0, rdy});
			lrun = 1'b1;
			for (i = 0; i < 4000 && q.size() > 0; i++) @(posedge mclk);
			if (q.size() > 0) begin
				n_mismatch++;
				close_out();
			end
			repeat (40) @(posedge mclk);
			lrun = 1'b0;
			chk("ready when empty", 8'h1, {7'h0, rdy});
		end
		chk("forwarded clock", 8'h1, {7'h0, seen});
		spd <= 1'b1;
		// last pass repeats mii half duplex with heartbeat switched off
		for (m = 0; m < 5; m++) begin
			mode <= CM[2*m +: 2];
			fd <= FD[m];
			hb <= m != 4;
			ec = CM[2*m +: 2] != 2'h1 && !FD[m];
			txen <= 1'b1;
			act <= 1'b1;
			repeat (8) @(posedge mclk);
			#1 chk("collision", {7'h0, ec}, {7'h0, col});
			chk("mac collision", {7'h0, CM[2*m +: 2] == 2'h1}, {7'h0, mcol});
			act <= 1'b0;
			repeat (4) @(posedge mclk);
			txen <= 1'b0;
			k = 8'h0;
			repeat (200) begin
				@(posedge mclk);
				#1 if (col !== 1'b0) k++;
			end
			chk("heartbeat cycles", ec && m != 4 ? 8'h7D : 8'h0, k);
		end
		do_reset(1'b1);
		seen <= 1'b0;
		lrun = 1'b1;
		repeat (40) @(posedge mclk);
		chk("forwarded clock off", 8'h0, {7'h0, seen});
		close_out();
	end
endmodule // prx_rx_status_test

`default_nettype wire
